// >>> hw/mpc_regs.svh
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// core clock period
`define MPC_CLK_NS 40
// monitor output refresh period and its cycle count
`define MPC_DAC_REFRESH_NS 100000
`define MPC_DAC_REFRESH_CYC ((`MPC_DAC_REFRESH_NS) / (`MPC_CLK_NS))
// speed ramp moves one count per wrap of this divider
`define MPC_RAMP_DIV 4'hF

// bit positions of the synchronised pin vector
`define MPC_PIN_BRAKE 0
`define MPC_PIN_ROT 1
`define MPC_PIN_DIS 2
`define MPC_PIN_WAKE 3

// buck output voltage select encodings
`define MPC_BUCK_SEL_3V3 2'h0
`define MPC_BUCK_SEL_5V 2'h1
`define MPC_BUCK_SEL_4V 2'h2
`define MPC_BUCK_SEL_5V7 2'h3
// buck current limit select encodings
`define MPC_BUCK_CURRENT_LIMIT_SELECT_600MA 1'h0
`define MPC_BUCK_CURRENT_LIMIT_SELECT_150MA 1'h1

// monitor variable addresses
`define MPC_VAR_SPEED 4'h0
`define MPC_VAR_STATE 4'h1
`define MPC_VAR_POS 4'h2
`define MPC_VAR_FAULT 4'h3
`define MPC_VAR_THRESH 4'h4
`define MPC_VAR_CMD 4'h5

`endif

// >>> hw/mpc_pkg.sv
package mpc_pkg;
   typedef enum logic [2:0] {ST_SLEEP, ST_RUN, ST_DECEL, ST_BRAKE, ST_COAST} mpc_state_t;
   typedef enum logic [1:0] {MODE_OFF, MODE_RUN, MODE_LSB, MODE_ALIGN} mpc_drive_t;
endpackage : mpc_pkg

// >>> hw/mpc_comm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mpc_comm_if;
   import mpc_pkg::*;
   logic step;
   logic dir;
   mpc_drive_t mode;
   logic [2:0] hs;
   logic [2:0] ls;
   logic [2:0] oe;
   logic fg;
   logic [1:0] pos;
   modport ctrl (output step, output dir, output mode,
      input hs, input ls, input oe, input fg, input pos);
   modport drv (input step, input dir, input mode,
      output hs, output ls, output oe, output fg, output pos);
endinterface : mpc_comm_if
`default_nettype wire

// >>> hw/mpc_commutator.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_commutator
   import mpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link to the controller
   mpc_comm_if.drv cif
);
   typedef struct packed {
      logic [1:0] pos;
      logic [2:0] hs;
      logic [2:0] ls;
      logic [2:0] oe;
      logic fg;
   } mpc_comm_st_t;

   mpc_comm_st_t c_r;
   mpc_comm_st_t c_nxt;

   // phase order A,B,C when dir high, A,C,B when low
   function automatic logic [1:0] mpc_next_pos(input logic [1:0] p, input logic d);
      if (d) begin
         mpc_next_pos = (p == 2'h2) ? 2'h0 : p + 2'h1;
      end else begin
         mpc_next_pos = (p == 2'h0) ? 2'h2 : p - 2'h1;
      end
   endfunction : mpc_next_pos

   function automatic logic [2:0] mpc_onehot(input logic [1:0] p);
      mpc_onehot = 3'h1 << p;
   endfunction : mpc_onehot

   always_comb begin
      c_nxt = c_r;
      case (cif.mode)
         MODE_RUN: begin
            if (cif.step) begin
               c_nxt.pos = mpc_next_pos(c_r.pos, cif.dir);
               c_nxt.fg = ~c_r.fg;
            end
            c_nxt.hs = mpc_onehot(c_nxt.pos);
            c_nxt.ls = mpc_onehot(mpc_next_pos(c_nxt.pos, cif.dir));
            c_nxt.oe = c_nxt.hs | c_nxt.ls;
         end
         MODE_LSB: begin
            c_nxt.hs = 3'h0;
            c_nxt.ls = 3'h7;
            c_nxt.oe = 3'h7;
         end
         MODE_ALIGN: begin
            c_nxt.hs = 3'h1;
            c_nxt.ls = 3'h6;
            c_nxt.oe = 3'h7;
         end
         default: begin
            // coast: every transistor off, position kept for restart
            c_nxt.hs = 3'h0;
            c_nxt.ls = 3'h0;
            c_nxt.oe = 3'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign cif.pos = c_r.pos;
   assign cif.hs = c_r.hs;
   assign cif.ls = c_r.ls;
   assign cif.oe = c_r.oe;
   assign cif.fg = c_r.fg;
endmodule : mpc_commutator
`default_nettype wire

// >>> hw/mpc_top.sv
`include "mpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mpc_top
   import mpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control pins
   input wire logic brake_pin,
   input wire logic rotation_pin,
   input wire logic output_disable_pin,
   input wire logic speed_wake_pin,
   // decoded speed command
   input wire logic [7:0] speed_command,
   // configuration
   input wire logic brake_override_en,
   input wire logic brake_override_val,
   input wire logic rotation_override_en,
   input wire logic rotation_override_val,
   input wire logic brake_align_mode,
   input wire logic [7:0] brake_speed_threshold,
   input wire logic [3:0] monitor_one_var_address,
   input wire logic [3:0] monitor_two_var_address,
   input wire logic alarm_pin_enable,
   input wire logic pullup_enable_saved,
   input wire logic [1:0] buck_sel,
   input wire logic buck_current_limit_select,
   input wire logic buck_sequencing_disable,
   // fault sources
   input wire logic [3:0] fault_actionable,
   input wire logic [3:0] fault_report_only,
   // bridge drive
   output logic [2:0] phase_hs,
   output logic [2:0] phase_ls,
   output logic [2:0] phase_oe,
   // monitor pins
   output logic speed_pulse_pin,
   output logic fault_low_pin_n,
   output logic alarm_pin_o,
   output logic alarm_pin_oe,
   output logic [7:0] monitor_dac_one,
   output logic [7:0] monitor_dac_two,
   // status
   output mpc_state_t motor_state,
   output logic [7:0] output_speed,
   output logic pullups_on,
   // buck configuration
   output logic [1:0] buck_vout_sel,
   output logic buck_limit_150ma,
   output logic buck_sequencing_active
);
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] lvl;
      mpc_state_t st;
      logic [7:0] speed;
      logic [3:0] ramp_cnt;
      logic [15:0] acc;
      logic step;
      logic [11:0] dac_cnt;
      logic [7:0] dac1;
      logic [7:0] dac2;
      logic fault_n;
      logic alarm;
      logic alarm_oe;
      logic pu_cap;
      logic pu_on;
      logic [1:0] vsel;
      logic lim150;
      logic seq_on;
   } mpc_top_st_t;

   mpc_top_st_t s_r;
   mpc_top_st_t s_nxt;
   mpc_comm_if cif ();

   logic brake_eff;
   logic rot_eff;
   logic wake;
   logic drv_dis;
   logic ramp_tick;
   logic act_any;
   logic rep_any;

   mpc_commutator u_comm (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cif(cif)
   );

   assign brake_eff = brake_override_en ? brake_override_val : s_r.lvl[`MPC_PIN_BRAKE];
   assign rot_eff = rotation_override_en ? rotation_override_val : s_r.lvl[`MPC_PIN_ROT];
   assign wake = s_r.lvl[`MPC_PIN_WAKE];
   assign drv_dis = s_r.lvl[`MPC_PIN_DIS];
   assign ramp_tick = (s_r.ramp_cnt == `MPC_RAMP_DIV);
   assign act_any = |fault_actionable;
   assign rep_any = |fault_report_only;

   function automatic logic [7:0] mpc_var_sel(input logic [3:0] a);
      case (a)
         `MPC_VAR_SPEED: mpc_var_sel = s_r.speed;
         `MPC_VAR_STATE: mpc_var_sel = {5'h00, s_r.st};
         `MPC_VAR_POS: mpc_var_sel = {6'h00, cif.pos};
         `MPC_VAR_FAULT: mpc_var_sel = {6'h00, s_r.alarm, s_r.fault_n};
         `MPC_VAR_THRESH: mpc_var_sel = brake_speed_threshold;
         `MPC_VAR_CMD: mpc_var_sel = speed_command;
         default: mpc_var_sel = 8'h00;
      endcase
   endfunction : mpc_var_sel

   always_comb begin
      logic [16:0] sum;
      sum = 17'h00000;
      s_nxt = s_r;
      // first stage feeds only the second; level moves once stages two and three agree
      s_nxt.s1 = {speed_wake_pin, output_disable_pin, rotation_pin, brake_pin};
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.lvl = (s_r.s3 & ~(s_r.s2 ^ s_r.s3)) | (s_r.lvl & (s_r.s2 ^ s_r.s3));
      s_nxt.ramp_cnt = s_r.ramp_cnt + 4'h1;
      if (!wake) begin
         s_nxt.st = ST_SLEEP;
         s_nxt.speed = 8'h00;
      end else if (drv_dis) begin
         // disable coasts but keeps the core running
         s_nxt.st = ST_COAST;
         s_nxt.speed = 8'h00;
      end else begin
         case (s_r.st)
            ST_SLEEP: s_nxt.st = ST_RUN;
            ST_COAST: begin
               // restart from standstill
               s_nxt.st = ST_RUN;
               s_nxt.speed = 8'h00;
            end
            ST_RUN: begin
               if (brake_eff) begin
                  s_nxt.st = ST_DECEL;
               end else if (ramp_tick && s_r.speed < speed_command) begin
                  s_nxt.speed = s_r.speed + 8'h01;
               end else if (ramp_tick && s_r.speed > speed_command) begin
                  s_nxt.speed = s_r.speed - 8'h01;
               end
            end
            ST_DECEL: begin
               if (!brake_eff) begin
                  s_nxt.st = ST_RUN;
               end else if (s_r.speed <= brake_speed_threshold) begin
                  s_nxt.st = ST_BRAKE;
                  s_nxt.speed = 8'h00;
               end else if (ramp_tick) begin
                  s_nxt.speed = s_r.speed - 8'h01;
               end
            end
            ST_BRAKE: begin
               if (!brake_eff) begin
                  s_nxt.st = ST_RUN;
               end
            end
            default: s_nxt.st = ST_SLEEP;
         endcase
      end
      // phase accumulator: carry rate follows speed
      if (s_r.st == ST_RUN || s_r.st == ST_DECEL) begin
         sum = {1'b0, s_r.acc} + {9'h000, s_r.speed};
         s_nxt.acc = sum[15:0];
         s_nxt.step = sum[16];
      end else begin
         s_nxt.acc = 16'h0000;
         s_nxt.step = 1'b0;
      end
      if (s_r.dac_cnt == 12'(`MPC_DAC_REFRESH_CYC - 1)) begin
         s_nxt.dac_cnt = 12'h000;
         s_nxt.dac1 = mpc_var_sel(monitor_one_var_address);
         s_nxt.dac2 = mpc_var_sel(monitor_two_var_address);
      end else begin
         s_nxt.dac_cnt = s_r.dac_cnt + 12'h001;
      end
      s_nxt.fault_n = ~(act_any | (rep_any & ~alarm_pin_enable));
      s_nxt.alarm = alarm_pin_enable & (act_any | rep_any);
      s_nxt.alarm_oe = alarm_pin_enable;
      // saved value only counts once per power-up
      if (!s_r.pu_cap) begin
         s_nxt.pu_cap = 1'b1;
         s_nxt.pu_on = pullup_enable_saved;
      end
      s_nxt.vsel = buck_sel;
      s_nxt.lim150 = (buck_current_limit_select == `MPC_BUCK_CURRENT_LIMIT_SELECT_150MA);
      s_nxt.seq_on = (buck_sequencing_disable == 1'b0)
         && (buck_sel == `MPC_BUCK_SEL_5V || buck_sel == `MPC_BUCK_SEL_5V7);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      cif.step = s_r.step;
      cif.dir = rot_eff;
      case (s_r.st)
         ST_RUN, ST_DECEL: cif.mode = MODE_RUN;
         ST_BRAKE: cif.mode = brake_align_mode ? MODE_ALIGN : MODE_LSB;
         default: cif.mode = MODE_OFF;
      endcase
   end

   assign phase_hs = cif.hs;
   assign phase_ls = cif.ls;
   assign phase_oe = cif.oe;
   assign speed_pulse_pin = cif.fg;
   assign fault_low_pin_n = s_r.fault_n;
   assign alarm_pin_o = s_r.alarm;
   assign alarm_pin_oe = s_r.alarm_oe;
   assign monitor_dac_one = s_r.dac1;
   assign monitor_dac_two = s_r.dac2;
   assign motor_state = s_r.st;
   assign output_speed = s_r.speed;
   assign pullups_on = s_r.pu_on;
   assign buck_vout_sel = s_r.vsel;
   assign buck_limit_150ma = s_r.lim150;
   assign buck_sequencing_active = s_r.seq_on;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_sleep;
      !wake |=> motor_state == ST_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep on wake low");
   property p_coast;
      wake && drv_dis |=> ##1 phase_oe == 3'h0;
   endproperty
   a_coast: assert property (p_coast) else $error("bridge not coasting");
   property p_disable_awake;
      wake && drv_dis |=> motor_state == ST_COAST;
   endproperty
   a_disable_awake: assert property (p_disable_awake) else $error("disable left coast");
   property p_brake_hold;
      motor_state == ST_BRAKE && brake_eff && wake && !drv_dis |=> motor_state == ST_BRAKE;
   endproperty
   a_brake_hold: assert property (p_brake_hold) else $error("brake state dropped");
   property p_brake_entry;
      $rose(motor_state == ST_BRAKE) |-> $past(motor_state) == ST_DECEL
         && $past(output_speed) <= $past(brake_speed_threshold);
   endproperty
   a_brake_entry: assert property (p_brake_entry) else $error("brake entered too fast");
   property p_brake_mode;
      motor_state == ST_BRAKE && brake_align_mode |=> phase_hs == 3'h1 && phase_ls == 3'h6;
   endproperty
   a_brake_mode: assert property (p_brake_mode) else $error("align brake wrong");
   property p_brake_ovr;
      brake_override_en && brake_override_val && motor_state == ST_RUN && wake && !drv_dis
         |=> motor_state == ST_DECEL;
   endproperty
   a_brake_ovr: assert property (p_brake_ovr) else $error("brake override ignored");
   property p_rot_ovr;
      // the step order must follow the override value, whatever the pin says
      rotation_override_en && cif.mode == MODE_RUN && cif.step
         |=> {1'b0, cif.pos} == ({1'b0, $past(cif.pos)}
         + ($past(rotation_override_val) ? 3'h1 : 3'h2)) % 3'h3;
   endproperty
   a_rot_ovr: assert property (p_rot_ovr) else $error("rotation override ignored");
   property p_dir_fwd;
      cif.mode == MODE_RUN && cif.step && cif.dir && cif.pos == 2'h0 |=> cif.pos == 2'h1;
   endproperty
   a_dir_fwd: assert property (p_dir_fwd) else $error("forward order wrong");
   property p_fg;
      $changed(speed_pulse_pin) |-> $past(cif.step);
   endproperty
   a_fg: assert property (p_fg) else $error("speed pulse without step");
   property p_report_only;
      alarm_pin_enable && rep_any && !act_any |=> fault_low_pin_n && alarm_pin_o;
   endproperty
   a_report_only: assert property (p_report_only) else $error("report fault routed wrong");
   property p_actionable;
      act_any |=> !fault_low_pin_n && (alarm_pin_o == $past(alarm_pin_enable));
   endproperty
   a_actionable: assert property (p_actionable) else $error("actionable fault missed");
   property p_alarm_off;
      !alarm_pin_enable && rep_any |=> !alarm_pin_oe && !fault_low_pin_n;
   endproperty
   a_alarm_off: assert property (p_alarm_off) else $error("disabled alarm wrong");
   property p_dac;
      $changed(monitor_dac_one) |-> s_r.dac_cnt == 12'h000;
   endproperty
   a_dac: assert property (p_dac) else $error("monitor changed off refresh");
   property p_buck_seq;
      buck_sequencing_active |-> buck_vout_sel == `MPC_BUCK_SEL_5V
         || buck_vout_sel == `MPC_BUCK_SEL_5V7;
   endproperty
   a_buck_seq: assert property (p_buck_seq) else $error("sequencing at low voltage");

   c_brake: cover property (motor_state == ST_DECEL ##1 motor_state == ST_BRAKE);
   c_coast_restart: cover property (motor_state == ST_COAST ##1 motor_state == ST_RUN);
   c_wake: cover property (motor_state == ST_SLEEP ##1 motor_state == ST_RUN);
endmodule : mpc_top
`default_nettype wire

// >>> tb/mpc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_ctrl_model (
   // clock
   input wire logic core_clk,
   // levels the controller wants on its pins
   input wire logic want_brake,
   input wire logic want_rot,
   input wire logic want_dis,
   input wire logic want_wake,
   // pins towards the device
   output logic brake_pin,
   output logic rotation_pin,
   output logic output_disable_pin,
   output logic speed_wake_pin
);
   // pins move on the edge, through nonblocking assignment, after the device has sampled them
   always @(posedge core_clk) begin
      brake_pin <= want_brake;
      rotation_pin <= want_rot;
      output_disable_pin <= want_dis;
      speed_wake_pin <= want_wake;
   end
endmodule : mpc_ctrl_model
`default_nettype wire

// >>> tb/mpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_top_tb;
   import mpc_pkg::*;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic brake_w = 1'h0, rot_w = 1'h1, dis_w = 1'h0, wake_w = 1'h1;
   logic brake_pin, rotation_pin, output_disable_pin, speed_wake_pin;
   logic [7:0] cmd = 8'h20, thr = 8'h08;
   logic brk_en = 1'h0, brk_val = 1'h0, rot_en = 1'h0, rot_val = 1'h0, align = 1'h0;
   logic [3:0] mon1 = 4'h4, mon2 = 4'h5, f_act = 4'h0, f_rep = 4'h0;
   logic alarm_en = 1'h0, pu_saved = 1'h1, cl = 1'h0, seq_dis = 1'h0;
   logic [1:0] bsel = 2'h0;
   logic [1:0] b_vsel;
   logic [2:0] hs, ls, oe;
   logic fgp, fault_n, alarm_o, alarm_oe, pu_on, b_lim, b_seq;
   logic [7:0] dac1, dac2, spd, prev_spd;
   mpc_state_t st;
   int err_count = 0;
   int cmp_count = 0;

   always #20 core_clk = ~core_clk;

   mpc_ctrl_model mpc_ctrl_model_i (.core_clk(core_clk), .want_brake(brake_w),
      .want_rot(rot_w), .want_dis(dis_w), .want_wake(wake_w), .brake_pin(brake_pin),
      .rotation_pin(rotation_pin), .output_disable_pin(output_disable_pin),
      .speed_wake_pin(speed_wake_pin));

   mpc_top mpc_top_i (.core_clk(core_clk), .rst_n(rst_n), .brake_pin(brake_pin),
      .rotation_pin(rotation_pin), .output_disable_pin(output_disable_pin),
      .speed_wake_pin(speed_wake_pin), .speed_command(cmd), .brake_override_en(brk_en),
      .brake_override_val(brk_val), .rotation_override_en(rot_en),
      .rotation_override_val(rot_val), .brake_align_mode(align), .brake_speed_threshold(thr),
      .monitor_one_var_address(mon1), .monitor_two_var_address(mon2),
      .alarm_pin_enable(alarm_en), .pullup_enable_saved(pu_saved), .buck_sel(bsel),
      .buck_current_limit_select(cl), .buck_sequencing_disable(seq_dis),
      .fault_actionable(f_act), .fault_report_only(f_rep), .phase_hs(hs), .phase_ls(ls),
      .phase_oe(oe), .speed_pulse_pin(fgp), .fault_low_pin_n(fault_n), .alarm_pin_o(alarm_o),
      .alarm_pin_oe(alarm_oe), .monitor_dac_one(dac1), .monitor_dac_two(dac2),
      .motor_state(st), .output_speed(spd), .pullups_on(pu_on), .buck_vout_sel(b_vsel),
      .buck_limit_150ma(b_lim), .buck_sequencing_active(b_seq));

   // sample one ns after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_st(input mpc_state_t got, input mpc_state_t exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_st

   // prev_spd keeps the speed of the cycle before the state arrived
   task automatic wait_st(input mpc_state_t s, input int lim);
      int n;
      n = 0;
      while (st !== s && n < lim) begin
         prev_spd = spd;
         tick(1);
         n++;
      end
      chk_st(st, s);
   endtask : wait_st

   task automatic wait_chg(input logic [2:0] a);
      int n;
      n = 0;
      while (hs === a && n < 1000) begin
         tick(1);
         n++;
      end
      chk({7'h0, hs !== a}, 8'h01);
   endtask : wait_chg

   task automatic t_buck;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         bsel <= i[1:0];
         cl <= i[0];
         seq_dis <= i[2];
         tick(3);
         chk({6'h0, b_vsel}, {6'h0, i[1:0]});
         chk({7'h0, b_lim}, {7'h0, i[0]});
         chk({7'h0, b_seq}, {7'h0, !i[2] && i[0]});
      end
      @(posedge core_clk);
      pu_saved <= 1'h0;
      tick(3);
      chk({7'h0, pu_on}, 8'h01);
      $display("buck and pull-up test done");
   endtask : t_buck

   task automatic t_fault;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         alarm_en <= i[2];
         f_act <= i[0] ? 4'h8 : 4'h0;
         f_rep <= i[1] ? 4'h1 : 4'h0;
         tick(3);
         chk({7'h0, fault_n}, {7'h0, !(i[0] || (i[1] && !i[2]))});
         chk({6'h0, alarm_oe, alarm_o}, {6'h0, i[2], i[2] && (i[0] || i[1])});
      end
      @(posedge core_clk);
      f_act <= 4'h0;
      f_rep <= 4'h0;
      $display("fault test done");
   endtask : t_fault

   // speed settles on the command during the first refresh wait; faults are clear with the alarm enabled
   task automatic t_mon;
      logic [3:0] adr1 [3];
      logic [3:0] adr2 [3];
      logic [7:0] exp1 [3];
      logic [7:0] exp2 [3];
      adr1 = '{`MPC_VAR_THRESH, `MPC_VAR_SPEED, `MPC_VAR_FAULT};
      adr2 = '{`MPC_VAR_CMD, `MPC_VAR_STATE, 4'hF};
      exp1 = '{thr, cmd, 8'h01};
      exp2 = '{cmd, {5'h00, ST_RUN}, 8'h00};
      for (int j = 0; j < 3; j++) begin
         @(posedge core_clk);
         mon1 <= adr1[j];
         mon2 <= adr2[j];
         tick(`MPC_DAC_REFRESH_CYC + 5);
         chk(dac1, exp1[j]);
         chk(dac2, exp2[j]);
      end
      $display("monitor test done");
   endtask : t_mon

   task automatic t_brake;
      @(posedge core_clk);
      brake_w <= 1'h1;
      wait_st(ST_DECEL, 10);
      wait_st(ST_BRAKE, 1000);
      chk({7'h0, prev_spd <= thr}, 8'h01);
      tick(50);
      chk_st(st, ST_BRAKE);
      chk({2'h0, ls, hs}, 8'h38);
      chk({5'h0, oe}, 8'h07);
      @(posedge core_clk);
      brk_en <= 1'h1;
      brk_val <= 1'h0;
      wait_st(ST_RUN, 10);
      @(posedge core_clk);
      brake_w <= 1'h0;
      brk_val <= 1'h1;
      align <= 1'h1;
      wait_st(ST_BRAKE, 1000);
      tick(3);
      chk({2'h0, ls, hs}, 8'h31);
      @(posedge core_clk);
      brk_en <= 1'h0;
      wait_st(ST_RUN, 10);
      $display("brake test done");
   endtask : t_brake

   task automatic t_coast;
      @(posedge core_clk);
      dis_w <= 1'h1;
      wait_st(ST_COAST, 10);
      tick(20);
      chk({5'h0, oe}, 8'h00);
      chk_st(st, ST_COAST);
      @(posedge core_clk);
      dis_w <= 1'h0;
      wait_st(ST_RUN, 10);
      chk(spd, 8'h00);
      @(posedge core_clk);
      wake_w <= 1'h0;
      wait_st(ST_SLEEP, 10);
      @(posedge core_clk);
      wake_w <= 1'h1;
      wait_st(ST_RUN, 10);
      $display("coast and sleep test done");
   endtask : t_coast

   task automatic t_dir(input logic pin, input logic ov, input logic val, input logic d);
      logic [2:0] a;
      logic sp;
      @(posedge core_clk);
      rot_w <= pin;
      rot_en <= ov;
      rot_val <= val;
      tick(10);
      wait_chg(hs);
      tick(2);
      a = hs;
      sp = fgp;
      wait_chg(a);
      tick(2);
      chk({5'h0, hs}, {5'h0, d ? {a[1:0], a[2]} : {a[0], a[2:1]}});
      chk({7'h0, fgp}, {7'h0, ~sp});
      $display("direction test done");
   endtask : t_dir

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
      wait_st(ST_RUN, 10);
      t_buck();
      t_fault();
      t_mon();
      t_brake();
      t_coast();
      @(posedge core_clk);
      cmd <= 8'hFF;
      tick(4200);
      t_dir(1'h1, 1'h0, 1'h0, 1'h1);
      t_dir(1'h1, 1'h1, 1'h0, 1'h0);
      t_dir(1'h0, 1'h0, 1'h0, 1'h0);
      t_dir(1'h0, 1'h1, 1'h1, 1'h1);
      end_sim();
   end

   // the tests need under 20000 cycles; allow three times that
   initial begin
      #(40 * 60000);
      err_count++;
      end_sim();
   end
endmodule : mpc_top_tb
`default_nettype wire
